// >>> shared/vfd_cmd_pkg.sv
// Shared constants for the symbol, port and duty command slice
package vfd_cmd_pkg;

    // ------------------------------------------------------------
    // Command codes in the upper four bits of a first byte
    // ------------------------------------------------------------
    localparam logic [3:0] OP_SYMBOL_WRITE = 4'h3;
    localparam logic [3:0] OP_GP_SET       = 4'h4;
    localparam logic [3:0] OP_DUTY_SET     = 4'h5;

    // ------------------------------------------------------------
    // Field positions, sizes and reset values
    // ------------------------------------------------------------
    localparam int OP_LSB          = 4;
    localparam int SYM_ADDR_W      = 4;
    localparam int SYM_DIGITS      = 16;
    localparam int SYM_BITS        = 2;
    localparam int DUTY_W          = 3;
    localparam int UPR_ADDR_W      = 3;
    localparam int PATTERN_BITS    = 35;
    localparam int ROM_PATTERNS    = 248;
    localparam int DUTY_SLOTS      = 16;
    localparam int DUTY_BASE       = 8;
    localparam logic [2:0] DUTY_RESET     = 3'h0;
    localparam logic [1:0] GP_RESET       = 2'h0;
    localparam logic [3:0] SYM_ADDR_RESET = 4'h0;

endpackage

// >>> shared/vfd_cmd_if.sv
// Byte link between host and display command decoder
`timescale 1ns/1ns
interface vfd_cmd_if;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_first;  // Marks a command byte, else data

    modport host   (output byte_valid, output byte_data, output byte_first);
    modport device (input byte_valid, input byte_data, input byte_first);
endinterface

// >>> hw/vfd_cmd_device.sv
// Device end: command decode for symbol RAM, output port and duty
//
// Behaviour
// - Three-bit user pattern address, eight entries
// - Each user pattern holds 35 dot bits
// - Character codes 0 to 7 select user patterns
// - Fixed ROM: eight-bit code, at most 248 patterns
// - Symbol write opcode 0011, low nibble start address
// - Symbol data bits 0 and 1 only
// - Symbol address increments after each data byte of a symbol write
// - Address F wraps to 0
// - Symbol address n drives grid n+1
// - Scanned symbol bits go straight to outputs
// - Port opcode 0100, bits 0 and 1 set pins
// - Port bit 1 high, 0 low, static
// - Port pins low during and after reset
// - Duty opcode 0101, bits 2 to 0 stored
// - Duty register selects one of eight stages
// - Duty register cleared by reset
// - Host sets duty before display on
// - Grid on-time is (8+k)/16 of digit
`timescale 1ns/1ns
module vfd_cmd_device
    import vfd_cmd_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  nrst_in,
    vfd_cmd_if.device                  link,
    input  wire logic [SYM_ADDR_W-1:0] scan_digit_in,
    input  wire logic [3:0]            scan_slot_in,
    input  wire logic [7:0]            char_code_in,
    output logic [1:0]                 gp_out,
    output logic [DUTY_W-1:0]          duty_out,
    output logic [SYM_BITS-1:0]        symbol_out,
    output logic [SYM_DIGITS-1:0]      grid_out,
    output logic                       user_sel_out,
    output logic [UPR_ADDR_W-1:0]      user_addr_out,
    output logic [7:0]                 rom_addr_out,
    output logic [SYM_ADDR_W-1:0]      sym_ptr_out
);

    // ------------------------------------------------------------
    // Decoder state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_SYMBOL = 1'b1
    } dec_state_t;

    dec_state_t                   state_r;
    dec_state_t                   state_nxt;
    logic [SYM_ADDR_W-1:0]        ptr_r;
    logic [SYM_ADDR_W-1:0]        ptr_nxt;
    logic [1:0]                   gp_r;
    logic [DUTY_W-1:0]            duty_r;
    logic [SYM_BITS-1:0]          sym_mem [SYM_DIGITS];
    logic [SYM_BITS-1:0]          symbol_r;
    logic [SYM_DIGITS-1:0]        grid_r;
    logic                         user_sel_r;
    logic [UPR_ADDR_W-1:0]        user_addr_r;
    logic [7:0]                   rom_addr_r;

    // ------------------------------------------------------------
    // Byte decode
    // ------------------------------------------------------------
    wire       cmd_byte  = link.byte_valid & link.byte_first;
    wire       data_byte = link.byte_valid & ~link.byte_first;
    wire [3:0] opcode    = link.byte_data[7:OP_LSB];
    wire       is_sym    = cmd_byte & (opcode == OP_SYMBOL_WRITE);
    wire       is_gp     = cmd_byte & (opcode == OP_GP_SET);
    wire       is_duty   = cmd_byte & (opcode == OP_DUTY_SET);
    wire       sym_wr    = data_byte & (state_r == ST_SYMBOL);

    // Payload fields of the current byte; the other bits are dropped
    wire [SYM_ADDR_W-1:0] start_addr = link.byte_data[SYM_ADDR_W-1:0];
    wire [SYM_BITS-1:0]   sym_bits   = link.byte_data[SYM_BITS-1:0];
    wire [1:0]            gp_bits    = link.byte_data[1:0];
    wire [DUTY_W-1:0]     duty_bits  = link.byte_data[DUTY_W-1:0];

    // ------------------------------------------------------------
    // Scan timing
    // ------------------------------------------------------------
    // Digit is lit while slot is below 8+k sixteenths
    wire [4:0] duty_lim  = 5'(DUTY_BASE) + {2'b00, duty_r};
    wire       grid_on   = {1'b0, scan_slot_in} < duty_lim;
    // One-hot grid: symbol address n lights grid n+1
    wire [SYM_DIGITS-1:0] grid_hot   = 16'h0001 << scan_digit_in;
    wire [SYM_DIGITS-1:0] grid_sel   = grid_on ? grid_hot : 16'h0000;
    // Stored bits of the scanned digit, no pattern lookup between
    wire [SYM_BITS-1:0]   symbol_sel = sym_mem[scan_digit_in];

    // ------------------------------------------------------------
    // Character code mapping
    // ------------------------------------------------------------
    // Codes below the first fixed-ROM code pick a user pattern
    localparam int ROM_FIRST   = 256 - ROM_PATTERNS;
    // Top dot index of one pattern word for the pattern store
    localparam int PATTERN_MSB = PATTERN_BITS - 1;
    wire                  user_hit  = char_code_in < 8'(ROM_FIRST);
    // Three low code bits address one of eight user patterns
    wire [UPR_ADDR_W-1:0] user_addr = char_code_in[UPR_ADDR_W-1:0];

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    // Next state: any command byte ends a data sequence
    always_comb
    begin
        state_nxt = state_r;
        ptr_nxt   = ptr_r;
        if (cmd_byte)
        begin
            state_nxt = is_sym ? ST_SYMBOL : ST_IDLE;
            if (is_sym)
                ptr_nxt = start_addr;
        end
        else if (sym_wr)
            ptr_nxt = ptr_r + 4'h1;
    end

    // Decoder state and symbol pointer
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r <= ST_IDLE;
            ptr_r   <= SYM_ADDR_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            ptr_r   <= ptr_nxt;
        end
    end

    // Port pins: static levels, low from reset until set
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            gp_r <= GP_RESET;
        else if (is_gp)
            gp_r <= gp_bits;
    end

    // Duty register, back to the 8/16 stage on reset
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            duty_r <= DUTY_RESET;
        else if (is_duty)
            duty_r <= duty_bits;
    end

    // ------------------------------------------------------------
    // Symbol storage
    // ------------------------------------------------------------
    // Not reset: a digit reads unknown until the host writes it
    always_ff @(posedge clk_in)
    begin
        if (sym_wr)
            sym_mem[ptr_r] <= sym_bits;
    end

    // ------------------------------------------------------------
    // Scan outputs
    // ------------------------------------------------------------
    // Symbol and grid drive, one cycle behind the scan inputs
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            symbol_r <= 2'h0;
            grid_r   <= 16'h0000;
        end
        else
        begin
            symbol_r <= symbol_sel;
            grid_r   <= grid_sel;
        end
    end

    // Character code routing, one cycle behind the code input
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            user_sel_r  <= 1'b0;
            user_addr_r <= 3'h0;
            rom_addr_r  <= 8'h00;
        end
        else
        begin
            user_sel_r  <= user_hit;
            user_addr_r <= user_addr;
            rom_addr_r  <= char_code_in;
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    assign gp_out        = gp_r;
    assign duty_out      = duty_r;
    assign symbol_out    = symbol_r;
    assign grid_out      = grid_r;
    assign user_sel_out  = user_sel_r;
    assign user_addr_out = user_addr_r;
    assign rom_addr_out  = rom_addr_r;
    assign sym_ptr_out   = ptr_r;

endmodule

// >>> hw/vfd_cmd_host.sv
// Host end: turns user requests into command and data bytes
`timescale 1ns/1ns
module vfd_cmd_host
    import vfd_cmd_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    vfd_cmd_if.host          link,
    input  wire logic        sym_start_in,
    input  wire logic [3:0]  sym_addr_in,
    input  wire logic        sym_data_in,
    input  wire logic [1:0]  sym_bits_in,
    input  wire logic        gp_set_in,
    input  wire logic [1:0]  gp_bits_in,
    input  wire logic        duty_set_in,
    input  wire logic [2:0]  duty_in
);

    // ------------------------------------------------------------
    // Byte formation, priority start > port > duty > data
    // ------------------------------------------------------------
    logic       valid_r;
    logic       first_r;
    logic [7:0] data_r;

    wire       any_req = sym_start_in | gp_set_in | duty_set_in | sym_data_in;
    wire       cmd_req = sym_start_in | gp_set_in | duty_set_in;
    wire [7:0] sym_cmd = {OP_SYMBOL_WRITE, sym_addr_in};
    wire [7:0] gp_cmd  = {OP_GP_SET, 2'b00, gp_bits_in};
    wire [7:0] dt_cmd  = {OP_DUTY_SET, 1'b0, duty_in};
    wire [7:0] sym_dat = {6'h00, sym_bits_in};
    wire [7:0] byte_sel = sym_start_in ? sym_cmd :
                          gp_set_in    ? gp_cmd  :
                          duty_set_in  ? dt_cmd  : sym_dat;

    // One byte per request, held one cycle
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            valid_r <= 1'b0;
            first_r <= 1'b0;
            data_r  <= 8'h00;
        end
        else
        begin
            valid_r <= any_req;
            first_r <= cmd_req;
            data_r  <= byte_sel;
        end
    end

    assign link.byte_valid = valid_r;
    assign link.byte_first = first_r;
    assign link.byte_data  = data_r;

endmodule

// >>> verification/vfd_cmd_props.sv
// Checker for the byte link and the decoded outputs of the device end
`timescale 1ns/1ns
module vfd_cmd_props
    import vfd_cmd_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic        byte_first,
    input  wire logic [3:0]  scan_digit_in,
    input  wire logic [3:0]  scan_slot_in,
    input  wire logic [7:0]  char_code_in,
    input  wire logic [1:0]  gp_out,
    input  wire logic [2:0]  duty_out,
    input  wire logic [15:0] grid_out,
    input  wire logic        user_sel_out,
    input  wire logic [2:0]  user_addr_out,
    input  wire logic [7:0]  rom_addr_out,
    input  wire logic [3:0]  sym_ptr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ------------------------------------------------------------
    // Command decode and symbol mode tracking
    // ------------------------------------------------------------
    wire logic       cmd_w = byte_valid && byte_first;
    wire logic       dat_w = byte_valid && !byte_first;
    wire logic [3:0] op_w  = byte_data[7:4];
    logic            sym_mode_r;
    always_ff @(posedge clk_in or negedge nrst_in)
        if (!nrst_in) sym_mode_r <= 1'b0;
        else if (cmd_w) sym_mode_r <= (op_w == OP_SYMBOL_WRITE);
    a_gp_cmd_sets: assert property (cmd_w && op_w == 4'h4 |=>
        gp_out == $past(byte_data[1:0])) else $error("port value wrong");
    a_duty_cmd_sets: assert property (cmd_w && op_w == 4'h5 |=>
        duty_out == $past(byte_data[2:0])) else $error("duty value wrong");
    a_sym_start_ptr: assert property (cmd_w && op_w == 4'h3 |=>
        sym_ptr_out == $past(byte_data[3:0])) else $error("start addr wrong");
    a_ptr_step_wrap: assert property (dat_w && sym_mode_r |=>
        sym_ptr_out == $past(sym_ptr_out) + 4'h1) else $error("no step");
    a_data_idle_hold: assert property (dat_w && !sym_mode_r |=>
        $stable(sym_ptr_out)) else $error("stray data moved pointer");
    a_other_cmd_hold: assert property (cmd_w && !(op_w inside {4'h3,
        4'h4, 4'h5}) |=> $stable(gp_out) && $stable(duty_out))
        else $error("unassigned code changed state");
    a_idle_link_hold: assert property (!byte_valid |=> $stable(gp_out)
        && $stable(duty_out) && $stable(sym_ptr_out)) else $error("drift");
    a_grid_duty_scan: assert property (nrst_in |=>
        grid_out == (({1'b0, $past(scan_slot_in)} < 5'h08 + $past(duty_out))
        ? 16'h0001 << $past(scan_digit_in) : 16'h0000)) else $error("grid");
    a_code_map_user: assert property (nrst_in |=>
        user_sel_out == ($past(char_code_in) < 8'h08) && user_addr_out ==
        $past(char_code_in[2:0]) && rom_addr_out == $past(char_code_in))
        else $error("code mapping wrong");
    c_wrap: cover property (dat_w && sym_mode_r && sym_ptr_out == 4'hF);
    c_duty_max: cover property (cmd_w && op_w == 4'h5 && byte_data[2:0] == 3'h7);
    c_user_code: cover property (char_code_in < 8'h08);
endmodule

// >>> verification/test_vfd_symbol_port_duty_commands.sv
// Self-checking bench: host end drives device end over the byte link
`timescale 1ns/1ns
module test_vfd_symbol_port_duty_commands
    import vfd_cmd_pkg::*;
;
    logic        clk_in = 0, nrst_in = 0, s_start = 0, s_data = 0;
    logic        g_set = 0, d_set = 0, usel_o;
    logic [3:0]  s_addr = 0, digit = 0, slot = 0, ptr_o, e_ptr = 0;
    logic [1:0]  s_bits = 0, g_bits = 0, gp_o, sym_o, e_gp = 0, mem[16];
    logic [2:0]  d_val = 0, duty_o, uaddr_o, e_duty = 0;
    logic [7:0]  code = 0, rom_o;
    logic [15:0] grid_o;
    logic [31:0] seed = 32'hD615028F;
    bit   [15:0] known = 0;
    bit          mode = 0;
    int          failures = 0, num_checks = 0, cyc = 0;
    vfd_cmd_if vfd_cmd_if_i();
    vfd_cmd_host vfd_cmd_host_i(.clk_in, .nrst_in, .link(vfd_cmd_if_i),
        .sym_start_in(s_start), .sym_addr_in(s_addr), .sym_data_in(s_data),
        .sym_bits_in(s_bits), .gp_set_in(g_set), .gp_bits_in(g_bits),
        .duty_set_in(d_set), .duty_in(d_val));
    vfd_cmd_device vfd_cmd_device_i(.clk_in, .nrst_in, .link(vfd_cmd_if_i),
        .scan_digit_in(digit), .scan_slot_in(slot), .char_code_in(code),
        .gp_out(gp_o), .duty_out(duty_o), .symbol_out(sym_o),
        .grid_out(grid_o), .user_sel_out(usel_o), .user_addr_out(uaddr_o),
        .rom_addr_out(rom_o), .sym_ptr_out(ptr_o));
    vfd_cmd_props vfd_cmd_props_i(.clk_in, .nrst_in,
        .byte_valid(vfd_cmd_if_i.byte_valid), .byte_data(vfd_cmd_if_i.byte_data),
        .byte_first(vfd_cmd_if_i.byte_first), .scan_digit_in(digit),
        .scan_slot_in(slot), .char_code_in(code), .gp_out(gp_o),
        .duty_out(duty_o), .grid_out(grid_o), .user_sel_out(usel_o),
        .user_addr_out(uaddr_o), .rom_addr_out(rom_o), .sym_ptr_out(ptr_o));
    // Random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        return s;
    endfunction
    // Grid expected from the slot against the 8+k sixteenths on-time
    function automatic logic [15:0] exp_grid(input logic [3:0] d,
        input logic [3:0] s, input logic [2:0] k);
        return (int'(s) < DUTY_BASE + int'(k)) ? (16'h0001 << d) : 16'h0000;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One host request, expected state update, then compare
    task automatic op(input logic [1:0] k, input logic [3:0] v);
        @(posedge clk_in);
        case (k)
            2'h0: begin s_start <= 1; s_addr <= v; e_ptr = v; mode = 1; end
            2'h1: begin s_data <= 1; s_bits <= v[1:0];
                if (mode) begin mem[e_ptr] = v[1:0]; known[e_ptr] = 1;
                    e_ptr = e_ptr + 4'h1; end end
            2'h2: begin g_set <= 1; g_bits <= v[1:0]; e_gp = v[1:0]; mode = 0; end
            2'h3: begin d_set <= 1; d_val <= v[2:0]; e_duty = v[2:0]; mode = 0; end
        endcase
        @(posedge clk_in);
        {s_start, s_data, g_set, d_set} <= 4'h0;
        repeat (2) @(posedge clk_in);
        #1;
        chk(gp_o, e_gp);
        chk(duty_o, e_duty);
        chk(ptr_o, e_ptr);
    endtask
    // Scan every digit and compare the stored symbol bits
    task automatic sweep();
        for (int d = 0; d < 16; d++)
        begin
            seed = xs(seed);
            @(posedge clk_in);
            digit <= d[3:0];
            slot <= seed[3:0];
            code <= seed[4] ? {5'h00, seed[2:0]} : seed[11:4];
            @(posedge clk_in);
            #1;
            if (known[d]) chk(sym_o, mem[d]);
            chk(grid_o, exp_grid(digit, slot, e_duty));
            chk({usel_o, uaddr_o}, {code < 8'h08, code[2:0]});
            chk(rom_o, code);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial forever #25 clk_in = ~clk_in;
    // Hang guard
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_in);
        nrst_in <= 1;
        op(2'h0, 4'hE); // Start near the top so the pointer wraps
        repeat (18) begin seed = xs(seed); op(2'h1, seed[3:0]); end
        sweep();
        repeat (250) begin seed = xs(seed); op(seed[1:0], seed[7:4]); end
        op(2'h3, 4'h7);
        sweep();
        op(2'h2, 4'h3);
        @(posedge clk_in);
        nrst_in <= 0;
        @(posedge clk_in);
        #1;
        chk(gp_o, 16'h0000);
        chk(duty_o, 16'h0000);
        chk(ptr_o, 16'h0000);
        @(posedge clk_in);
        nrst_in <= 1;
        {e_gp, e_duty, e_ptr, mode} = 0;
        op(2'h1, 4'h2); // Data byte right after reset is ignored
        sweep();
        final_report();
    end
endmodule
